//--- logic/aocr_pkg.sv
// Package with register map, reset values, field layout and types of the config slice.
package aocr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned AW = 13;
  localparam logic [12:0] OFS_TEST_SEL  = 13'h00d;
  localparam logic [12:0] OFS_OFFSET    = 13'h010;
  localparam logic [12:0] OFS_FORMAT    = 13'h014;
  localparam logic [12:0] OFS_DIV_PHASE = 13'h016;
  localparam logic [12:0] OFS_DCO_DELAY = 13'h017;
  localparam logic [12:0] OFS_RANGE     = 13'h018;
  localparam logic [12:0] OFS_SYNC      = 13'h100;

  localparam logic [7:0] RST_TEST_SEL  = 8'h00;
  localparam logic [7:0] RST_OFFSET    = 8'h00;
  localparam logic [7:0] RST_FORMAT    = 8'h00;
  localparam logic [7:0] RST_DIV_PHASE = 8'h00;
  localparam logic [7:0] RST_DCO_DELAY = 8'h00;
  localparam logic [7:0] RST_RANGE     = 8'hc0;
  localparam logic [7:0] RST_SYNC      = 8'h00;

  // Writable bits; open bits are dropped on write and read as zero.
  localparam logic [7:0] MSK_TEST_SEL  = 8'h07;
  localparam logic [7:0] MSK_OFFSET    = 8'h3f;
  localparam logic [7:0] MSK_FORMAT    = 8'hf7;
  localparam logic [7:0] MSK_DIV_PHASE = 8'h87;
  localparam logic [7:0] MSK_DCO_DELAY = 8'h1f;
  localparam logic [7:0] MSK_RANGE     = 8'hc0;
  localparam logic [7:0] MSK_SYNC      = 8'hff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned FMT_INVERT_BIT = 2;
  localparam int unsigned FMT_OE_BAR_BIT = 4;
  localparam int unsigned FMT_ILV_BIT    = 5;
  localparam int unsigned FMT_LVDS_BIT   = 6;
  localparam int unsigned FMT_DRIVE_BIT  = 7;
  localparam int unsigned PH_INV_DCO_BIT = 7;
  localparam int unsigned SY_MASTER      = 0;
  localparam int unsigned SY_DIV_EN      = 1;
  localparam int unsigned SY_DIV_ONCE    = 2;
  localparam int unsigned SY_OSC_EN      = 3;
  localparam int unsigned SY_OSC_ONCE    = 4;
  localparam int unsigned SY_HB_EN       = 5;
  localparam int unsigned SY_HB_ONCE     = 6;
  localparam int unsigned SY_MON_EN      = 7;

  // ----------------------------------------------------------------
  // Codes and constants
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AOCR_TEST_OFF  = 3'h0,
    AOCR_TEST_MID  = 3'h1,
    AOCR_TEST_PFS  = 3'h2,
    AOCR_TEST_NFS  = 3'h3
  } aocr_test_t;

  localparam logic [1:0] FMT_OFFSET_BIN = 2'h0;
  localparam logic [1:0] FMT_TWOS       = 2'h1;
  localparam int unsigned SAMPLE_W      = 14;
  localparam int unsigned DCO_FULL_PS   = 2500;
  localparam int unsigned DCO_STEPS     = 31;

  typedef struct packed {
    logic [7:0] test_sel;
    logic [7:0] offset;
    logic [7:0] format;
    logic [7:0] div_phase;
    logic [7:0] dco_delay;
    logic [7:0] range;
    logic [7:0] sync;
  } aocr_regs_t;

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0]  wdata;
    logic        wr;
  } aocr_reg_req_t;

  typedef struct packed {
    logic osc;
    logic hb;
    logic mon;
  } aocr_sync_out_t;

endpackage : aocr_pkg

//--- logic/aocr_sync2.sv
// Two-stage synchroniser for levels entering the converter clock domain.
`timescale 1ns/1ns
`default_nettype none
module aocr_sync2 (
  input  wire logic clk,     // Destination clock.
  input  wire logic rst_n,   // Asynchronous reset, active low.
  input  wire logic d,       // Asynchronous level.
  output logic      q        // Synchronised level.
);
  logic meta_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // aocr_sync2
`default_nettype wire

//--- logic/aocr_top.sv
// Output, clock and sync configuration registers with the datapath they steer.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Test field picks normal, midscale, +full_scale, -full_scale.
// - Selected test pattern replaces samples on outputs.
// - Signed six-bit offset added to each channel.
// - Format code 01 gives twos-complement output.
// - Divider phase delays divider by 0-7 cycles.
// - Output clock delay is 2500ps times code/31.
module aocr_top (
  input  wire logic                    core_clk,      // Converter clock, 10 MHz.
  input  wire logic                    resetn,        // Asynchronous reset, active low.
  input  wire aocr_pkg::aocr_reg_req_t reg_req,       // Register write port from the serial port.
  output logic [7:0]                   reg_rdata,     // Read data for reg_req.addr, registered.
  input  wire logic [13:0]             adc_a,         // Channel A sample, offset binary.
  input  wire logic [13:0]             adc_b,         // Channel B sample, offset binary.
  output logic [13:0]                  dout_a,        // Channel A output data.
  output logic [13:0]                  dout_b,        // Channel B output data.
  output logic                         dout_oe,       // Output drivers enabled.
  output logic [2:0]                   out_ctrl,      // Drive strength, LVDS, interleave.
  input  wire logic [2:0]              div_ratio,     // Divide code, 0 is divide by 1.
  output logic                         div_clk_en,    // Divided clock enable pulse.
  output logic                         dco_invert,    // Invert output_data_clock.
  output logic [11:0]                  dco_delay_ps,  // output_data_clock delay in ps.
  output logic [1:0]                   range_sel,     // Input range select.
  input  wire logic                    sync_pin,      // Asynchronous sync input.
  output aocr_pkg::aocr_sync_out_t     unit_sync      // One-cycle sync pulses to units.
);
  import aocr_pkg::*;

  typedef struct packed {
    aocr_regs_t     regs;
    logic [7:0]     rdata;
    logic [13:0]    da;
    logic [13:0]    db;
    logic [2:0]     cnt;
    logic [2:0]     hold;
    logic           div_en;
    logic           sync_prev;
    aocr_sync_out_t usync;
    logic           div_sync;
  } aocr_state_t;

  aocr_state_t st_q;
  aocr_state_t st_d;
  logic        rst_n;
  logic        sync_s;
  logic        sync_edge;
  logic [2:0]  widx;

  // ----------------------------------------------------------------
  // Reset release and sync pin crossing
  // ----------------------------------------------------------------
  aocr_sync2 u_rst_sync (
    .clk   (core_clk),
    .rst_n (resetn),
    .d     (1'b1),
    .q     (rst_n)
  );

  aocr_sync2 u_pin_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     (sync_pin),
    .q     (sync_s)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_index(input logic [12:0] a);
    unique case (a)
      OFS_TEST_SEL:  reg_index = 3'h0;
      OFS_OFFSET:    reg_index = 3'h1;
      OFS_FORMAT:    reg_index = 3'h2;
      OFS_DIV_PHASE: reg_index = 3'h3;
      OFS_DCO_DELAY: reg_index = 3'h4;
      OFS_RANGE:     reg_index = 3'h5;
      OFS_SYNC:      reg_index = 3'h6;
      default:       reg_index = 3'h7;
    endcase
  endfunction

  // Pattern select, offset trim with saturation, then format and invert.
  function automatic logic [13:0] shape(input logic [13:0] smp, input aocr_regs_t r);
    logic [14:0] sum;
    logic [13:0] v;
    sum = 15'h0000;
    v   = smp;
    unique case (r.test_sel[2:0])
      AOCR_TEST_MID: v = 14'h2000;
      AOCR_TEST_PFS: v = 14'h3fff;
      AOCR_TEST_NFS: v = 14'h0000;
      default:       v = smp;
    endcase
    sum = {1'b0, v} + {{9{r.offset[5]}}, r.offset[5:0]};
    if (r.offset[5] && sum[14])
      v = 14'h0000;
    else if (!r.offset[5] && sum[14])
      v = 14'h3fff;
    else
      v = sum[13:0];
    if (r.format[1:0] == FMT_TWOS)
      v[13] = ~v[13];
    if (r.format[FMT_INVERT_BIT])
      v = ~v;
    shape = v;
  endfunction

  assign sync_edge = sync_s & ~st_q.sync_prev;
  assign widx      = reg_index(reg_req.addr);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d           = st_q;
    st_d.sync_prev = sync_s;
    st_d.usync     = '0;
    st_d.div_sync  = 1'b0;

    if (sync_edge && st_q.regs.sync[SY_MASTER])
    begin
      if (st_q.regs.sync[SY_DIV_EN])
      begin
        st_d.div_sync = 1'b1;
        if (st_q.regs.sync[SY_DIV_ONCE])
          st_d.regs.sync[SY_DIV_EN] = 1'b0;
      end
      if (st_q.regs.sync[SY_OSC_EN])
      begin
        st_d.usync.osc = 1'b1;
        if (st_q.regs.sync[SY_OSC_ONCE])
          st_d.regs.sync[SY_OSC_EN] = 1'b0;
      end
      if (st_q.regs.sync[SY_HB_EN])
      begin
        st_d.usync.hb = 1'b1;
        if (st_q.regs.sync[SY_HB_ONCE])
          st_d.regs.sync[SY_HB_EN] = 1'b0;
      end
      st_d.usync.mon = st_q.regs.sync[SY_MON_EN];
    end

    // A host write lands after the one-shot clear, so it wins.
    if (reg_req.wr)
    begin
      unique case (widx)
        3'h0: st_d.regs.test_sel  = reg_req.wdata & MSK_TEST_SEL;
        3'h1: st_d.regs.offset    = reg_req.wdata & MSK_OFFSET;
        3'h2: st_d.regs.format    = reg_req.wdata & MSK_FORMAT;
        3'h3: st_d.regs.div_phase = reg_req.wdata & MSK_DIV_PHASE;
        3'h4: st_d.regs.dco_delay = reg_req.wdata & MSK_DCO_DELAY;
        3'h5: st_d.regs.range     = reg_req.wdata & MSK_RANGE;
        3'h6: st_d.regs.sync      = reg_req.wdata & MSK_SYNC;
        default: ;
      endcase
    end

    unique case (widx)
      3'h0: st_d.rdata = st_q.regs.test_sel;
      3'h1: st_d.rdata = st_q.regs.offset;
      3'h2: st_d.rdata = st_q.regs.format;
      3'h3: st_d.rdata = st_q.regs.div_phase;
      3'h4: st_d.rdata = st_q.regs.dco_delay;
      3'h5: st_d.rdata = st_q.regs.range;
      3'h6: st_d.rdata = st_q.regs.sync;
      default: st_d.rdata = 8'h00;
    endcase

    // The phase hold stalls the divider after a sync, shifting its output edges.
    if (st_d.div_sync)
    begin
      st_d.hold   = st_q.regs.div_phase[2:0];
      st_d.cnt    = 3'h0;
      st_d.div_en = 1'b0;
    end
    else if (st_q.hold != 3'h0)
    begin
      st_d.hold   = st_q.hold - 3'h1;
      st_d.div_en = 1'b0;
    end
    else
    begin
      st_d.div_en = (st_q.cnt == 3'h0);
      st_d.cnt    = (st_q.cnt == div_ratio) ? 3'h0 : st_q.cnt + 3'h1;
    end

    st_d.da = shape(adc_a, st_q.regs);
    st_d.db = shape(adc_b, st_q.regs);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q                <= '0;
      st_q.regs.test_sel  <= RST_TEST_SEL;
      st_q.regs.offset    <= RST_OFFSET;
      st_q.regs.format    <= RST_FORMAT;
      st_q.regs.div_phase <= RST_DIV_PHASE;
      st_q.regs.dco_delay <= RST_DCO_DELAY;
      st_q.regs.range     <= RST_RANGE;
      st_q.regs.sync      <= RST_SYNC;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [16:0] dco_prod;
  assign dco_prod     = 17'(st_q.regs.dco_delay[4:0] * DCO_FULL_PS);
  assign dco_delay_ps = 12'(dco_prod / 17'(DCO_STEPS));
  assign reg_rdata    = st_q.rdata;
  assign dout_a       = st_q.da;
  assign dout_b       = st_q.db;
  assign dout_oe      = ~st_q.regs.format[FMT_OE_BAR_BIT];
  assign out_ctrl     = st_q.regs.format[FMT_DRIVE_BIT:FMT_ILV_BIT];
  assign div_clk_en   = st_q.div_en;
  assign dco_invert   = st_q.regs.div_phase[PH_INV_DCO_BIT];
  assign range_sel    = st_q.regs.range[7:6];
  assign unit_sync    = st_q.usync;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic plain_fmt;
  assign plain_fmt = st_q.regs.offset[5:0] == 6'h00 && st_q.regs.format[2:0] == 3'h0;

  sequence s_div_held3;
    !div_clk_en [*4] ##1 div_clk_en;
  endsequence

  a_mid_pattern: assert property (st_q.regs.test_sel[2:0] == 3'h1 && plain_fmt |=>
    dout_a == 14'h2000 && dout_b == 14'h2000) else $error("midscale pattern wrong");
  a_pos_full: assert property (st_q.regs.test_sel[2:0] == 3'h2 && plain_fmt |=>
    dout_a == 14'h3fff) else $error("positive full scale wrong");
  a_neg_full: assert property (st_q.regs.test_sel[2:0] == 3'h3 && plain_fmt |=>
    dout_b == 14'h0000) else $error("negative full scale wrong");
  a_normal_pass: assert property (st_q.regs.test_sel[2:0] == 3'h0 && plain_fmt |=>
    dout_a == $past(adc_a) && dout_b == $past(adc_b)) else $error("samples not passed");
  a_offset_apply: assert property (st_q.regs.test_sel[2:0] == 3'h1 &&
    st_q.regs.format[2:0] == 3'h0 |=>
    dout_a == 14'(14'h2000 + {{8{$past(st_q.regs.offset[5])}}, $past(st_q.regs.offset[5:0])}))
    else $error("offset not applied");
  a_twos_fmt: assert property (st_q.regs.test_sel[2:0] == 3'h2 &&
    st_q.regs.offset[5:0] == 6'h00 && st_q.regs.format[2:0] == 3'h1 |=> dout_a == 14'h1fff)
    else $error("twos complement format wrong");
  a_phase_hold: assert property (st_d.div_sync && st_q.regs.div_phase[2:0] == 3'h3 &&
    div_ratio == 3'h0 |=> s_div_held3) else $error("divider phase delay wrong");
  a_dco_full: assert property (reg_req.wr && reg_req.addr == OFS_DCO_DELAY &&
    reg_req.wdata[4:0] == 5'h1f |=> dco_delay_ps == 12'd2500) else $error("delay not 2500 ps");
  a_sync_gate: assert property (!st_q.regs.sync[SY_MASTER] |=>
    !unit_sync.osc && !unit_sync.hb && !unit_sync.mon) else $error("sync without master");
  a_once_clear: assert property (sync_edge && st_q.regs.sync[1:0] == 2'h3 &&
    st_q.regs.sync[SY_DIV_ONCE] && !reg_req.wr |=> !st_q.regs.sync[SY_DIV_EN])
    else $error("next sync only not cleared");

endmodule // aocr_top
`default_nettype wire

//--- dv/aocr_host_model.sv
// Host model that writes and addresses the configuration registers.
`timescale 1ns/1ns
`default_nettype none
module aocr_host_model (
  input  wire logic              clk,  // Bench clock.
  output var aocr_pkg::aocr_reg_req_t req   // Register request.
);
  import aocr_pkg::*;
  initial req = '0;
  // Codes above 3 are undefined, so the host never lets bit 2 of the test field through.
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{addr: a, wdata: (a == OFS_TEST_SEL) ? (d & 8'h03) : d, wr: 1'b1};
    @(negedge clk);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [12:0] a);
    @(negedge clk);
    req = '{addr: a, wdata: 8'h00, wr: 1'b0};
    @(negedge clk);
  endtask
endmodule // aocr_host_model
`default_nettype wire

//--- dv/adc_output_clock_config_regs_tb.sv
// Self-checking bench for the output, clock and sync configuration registers.
`timescale 1ns/1ns
`default_nettype none
module adc_output_clock_config_regs_tb;
  import aocr_pkg::*;
  logic           core_clk = 1'b0;
  logic           resetn = 1'b0;
  aocr_reg_req_t  reg_req;
  logic [7:0]     reg_rdata;
  logic [13:0]    adc_a = '0;
  logic [13:0]    adc_b = '0;
  logic [13:0]    dout_a, dout_b;
  logic           dout_oe, div_clk_en, dco_invert, sync_pin = 1'b0;
  logic [2:0]     out_ctrl;
  logic [2:0]     div_ratio = 3'h7;
  logic [11:0]    dco_delay_ps;
  logic [1:0]     range_sel;
  aocr_sync_out_t unit_sync;
  logic [31:0]    seed = 32'h14;
  logic [15:0]    meas = '0;
  logic [18:0]    n;
  logic [18:0]    exp_q [$];
  event           look;
  int             error_cnt = 0;
  int             compares = 0;
  logic [12:0]    ofs [7] = '{OFS_TEST_SEL, OFS_OFFSET, OFS_FORMAT, OFS_DIV_PHASE,
                              OFS_DCO_DELAY, OFS_RANGE, OFS_SYNC};
  logic [7:0]     rst [7] = '{RST_TEST_SEL, RST_OFFSET, RST_FORMAT, RST_DIV_PHASE,
                              RST_DCO_DELAY, RST_RANGE, RST_SYNC};
  logic [7:0]     msk [7] = '{MSK_TEST_SEL, MSK_OFFSET, MSK_FORMAT, MSK_DIV_PHASE,
                              MSK_DCO_DELAY, MSK_RANGE, MSK_SYNC};
  logic [7:0]     oc [4] = '{8'h00, 8'h20, 8'h1f, 8'h05};
  logic [7:0]     fc [4] = '{8'h00, 8'h01, 8'h04, 8'h05};
  int             ph [3] = '{0, 3, 7};

  always #50 core_clk = ~core_clk;

  aocr_top dut_u (
    .core_clk     (core_clk),
    .resetn       (resetn),
    .reg_req      (reg_req),
    .reg_rdata    (reg_rdata),
    .adc_a        (adc_a),
    .adc_b        (adc_b),
    .dout_a       (dout_a),
    .dout_b       (dout_b),
    .dout_oe      (dout_oe),
    .out_ctrl     (out_ctrl),
    .div_ratio    (div_ratio),
    .div_clk_en   (div_clk_en),
    .dco_invert   (dco_invert),
    .dco_delay_ps (dco_delay_ps),
    .range_sel    (range_sel),
    .sync_pin     (sync_pin),
    .unit_sync    (unit_sync)
  );
  aocr_host_model hm (.clk(core_clk), .req(reg_req));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Test patterns go through the offset adder too, so they saturate like samples.
  function automatic logic [13:0] ref_dp(logic [13:0] s, logic [2:0] t, logic [5:0] o,
                                         logic [7:0] f);
    int v;
    v = (t == 3'h1) ? 'h2000 : (t == 3'h2) ? 'h3fff : (t == 3'h3) ? 0 : int'(s);
    v += $signed(o);
    v = (v < 0) ? 0 : (v > 'h3fff) ? 'h3fff : v;
    ref_dp = 14'(v);
    if (f[1:0] == FMT_TWOS) ref_dp[13] = ~ref_dp[13];
    if (f[FMT_INVERT_BIT]) ref_dp = ~ref_dp;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic note(input logic [2:0] s, input logic [15:0] e);
    exp_q.push_back({s, e});
    -> look;
    #1;
  endtask

  task automatic end_of_test();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Gap counts edges from the oscillator pulse to the first divider enable.
  task automatic pulse_sync(output int gap, output logic [2:0] got);
    bit armed;
    int k;
    armed = 1'b0;
    k = 0;
    gap = -1;
    got = '0;
    sync_pin = 1'b1;
    repeat (24)
    begin
      @(negedge core_clk);
      if (armed) k++;
      if (armed && gap < 0 && div_clk_en === 1'b1) gap = k;
      if (unit_sync.osc === 1'b1) armed = 1'b1;
      got |= unit_sync;
    end
    sync_pin = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask

  always
  begin
    @(look);
    while (exp_q.size() > 0)
    begin
      n = exp_q.pop_front();
      case (n[18:16])
        3'd0: check(16'(dout_a), n[15:0]);
        3'd1: check(16'(dout_b), n[15:0]);
        3'd2: check(16'(reg_rdata), n[15:0]);
        3'd3: check(16'(dco_delay_ps), n[15:0]);
        3'd4: check(16'({range_sel, dout_oe, out_ctrl, dco_invert}), n[15:0]);
        default: check(meas, n[15:0]);
      endcase
    end
  end

  initial
  begin
    #1_000_000;
    error_cnt++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    int gap, gap0;
    logic [2:0] got;
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    repeat (3) @(negedge core_clk);
    note(3'd4, 16'h0070);
    for (int i = 0; i < 7; i++)
    begin
      hm.rd(ofs[i]);
      note(3'd2, 16'(rst[i]));
      hm.wr(ofs[i], 8'hff);
      hm.rd(ofs[i]);
      note(3'd2, 16'(msk[i] & ((i == 0) ? 8'h03 : 8'hff)));
    end
    note(3'd4, 16'h006f);
    hm.wr(13'h011, 8'h5a);
    hm.rd(13'h011);
    note(3'd2, 16'h0000);
    for (int i = 0; i < 7; i++) hm.wr(ofs[i], rst[i]);
    for (int i = 0; i < 64; i++)
    begin
      hm.wr(OFS_TEST_SEL, 8'(i[1:0]));
      hm.wr(OFS_OFFSET, oc[i[3:2]]);
      hm.wr(OFS_FORMAT, fc[i[5:4]]);
      @(negedge core_clk);
      adc_a = 14'(xs());
      adc_b = seed[0] ? 14'h3ff0 : 14'h0010;
      @(negedge core_clk);
      note(3'd0, 16'(ref_dp(adc_a, 3'(i[1:0]), oc[i[3:2]][5:0], fc[i[5:4]])));
      note(3'd1, 16'(ref_dp(adc_b, 3'(i[1:0]), oc[i[3:2]][5:0], fc[i[5:4]])));
    end
    for (int c = 0; c < 32; c++)
    begin
      hm.wr(OFS_DCO_DELAY, 8'(c));
      note(3'd3, 16'((DCO_FULL_PS * c) / DCO_STEPS));
    end
    hm.wr(OFS_SYNC, 8'h0b);
    // Divide by one, so the phase hold is the only thing that delays the enable.
    div_ratio = 3'h0;
    gap0 = 0;
    foreach (ph[i])
    begin
      hm.wr(OFS_DIV_PHASE, 8'(ph[i]));
      pulse_sync(gap, got);
      if (i == 0) gap0 = gap;
      meas = 16'(gap - gap0);
      note(3'd7, 16'(ph[i]));
    end
    hm.wr(OFS_SYNC, 8'h2a);
    pulse_sync(gap, got);
    meas = 16'(got);
    note(3'd7, 16'h0000);
    hm.wr(OFS_SYNC, 8'hbf);
    pulse_sync(gap, got);
    meas = 16'(got);
    note(3'd7, 16'h0007);
    hm.rd(OFS_SYNC);
    note(3'd2, 16'h00b5);
    pulse_sync(gap, got);
    meas = 16'(got);
    note(3'd7, 16'h0003);
    end_of_test();
  end
endmodule // adc_output_clock_config_regs_tb
`default_nettype wire
